// *** omcs_pkg.sv ***
// =====================================================================
// omcs_pkg: constants for the nvm manual command sequencer
// =====================================================================
// register offsets, field positions, reset values and command codes.
// assumes a 32-bit apb bus with one aligned word per register.
package omcs_pkg;

  // ===================================================================
  // register byte offsets
  // ===================================================================
  localparam logic [7:0] OFS_RECOVERY_TIMING = 8'h00;
  localparam logic [7:0] OFS_ACCESS_KEY = 8'h04;
  localparam logic [7:0] OFS_TICK_DIVIDER = 8'h08;
  localparam logic [7:0] OFS_CMD_TIMING = 8'h0C;
  localparam logic [7:0] OFS_CMD_SELECT = 8'h10;
  localparam logic [7:0] OFS_START_STATUS = 8'h14;

  // ===================================================================
  // field positions
  // ===================================================================
  localparam int RST_REC_LSB = 9;
  localparam int RST_REC_MSB = 15;
  localparam int PSR_LSB = 0;
  localparam int PSR_MSB = 8;
  localparam int PULSE_LSB = 14;
  localparam int PULSE_MSB = 31;
  localparam int RECOV_LSB = 4;
  localparam int RECOV_MSB = 13;
  localparam int HOLD_LSB = 2;
  localparam int HOLD_MSB = 3;
  localparam int SETUP_LSB = 0;
  localparam int SETUP_MSB = 1;
  localparam int MASK_LSB = 4;
  localparam int MASK_MSB = 7;
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 3;
  localparam int START_BIT = 0;
  localparam int REFUSED_BIT = 1;

  // ===================================================================
  // reset values
  // ===================================================================
  localparam logic [15:0] RST_RECOVERY_TIMING = 16'h3B2C;
  localparam logic [7:0] RST_ACCESS_KEY = 8'h00;
  localparam logic [7:0] RST_TICK_DIVIDER = 8'h77;
  localparam logic [31:0] RST_CMD_TIMING = 32'h0001_8070;
  localparam logic [7:0] RST_CMD_SELECT = 8'h00;

  // key value that opens manual access
  localparam logic [7:0] KEY_OPEN = 8'h97;

  // ===================================================================
  // command codes
  // ===================================================================
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESET = 4'h1;
  localparam logic [3:0] CMD_POWER_UP = 4'h4;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h5;
  localparam logic [3:0] CMD_READ = 4'h6;
  localparam logic [3:0] CMD_WRITE = 4'h7;
  localparam logic [3:0] CMD_PROGRAM = 4'h8;
  localparam logic [3:0] CMD_COMPARE = 4'h9;
  localparam logic [3:0] CMD_PRECHARGE = 4'hA;
  localparam logic [3:0] CMD_AUX_UPDATE = 4'hB;
  localparam logic [3:0] CMD_WAIT = 4'hD;
  localparam logic [3:0] CMD_PGM_ASSIST = 4'hE;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_RECOV,
    ST_PSR,
    ST_RST
  } omcs_state_t;

endpackage : omcs_pkg

// *** omcs_timer.sv ***
// =====================================================================
// omcs_timer: loadable down counter for stage and recovery lengths
// =====================================================================
// single pclk domain; the caller loads a length and steps it down.
module omcs_timer
  import omcs_pkg::*;
#(
  parameter int WIDTH = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic step,
  output logic zero
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  initial begin
    if (WIDTH < 2) begin
      $error("omcs_timer width too small");
    end
  end

  // load wins; stepping stops at zero so it never wraps
  assign nxt_cnt = load ? load_val :
                   (step && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign zero = (cnt_ff == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : omcs_timer

// *** omcs_sequencer.sv ***
// =====================================================================
// omcs_sequencer: manual command sequencer for the nvm macro
// =====================================================================
// apb slave with timing, key and command registers; drives the macro.
// assumes pclk is the single system clock and the macro is synchronous.
//
// Overview of operation
// R1: reset recovery in 4-cycle units, default 0x1D
// R2: supply recovery in microsecond ticks, default 0x12C
// R3: start allowed only while key holds 0x97
// R4: tick every divider plus one cycles
// R5: pulse stage lasts field plus one cycles
// R6: recovery stage lasts field plus one cycles
// R7: hold stage lasts field plus one cycles
// R8: setup stage lasts field plus one cycles
// R9: assist steps reuse setup, pulse, recovery lengths
// R10: software sets pulse field to 6
// R11: software sets recovery field to 7
// R12: software sets setup field to 0
// R13: stage mask bits enable setup, pulse, hold, recovery
// R14: software picks recommended stage mask per command
// R15: command code decoded per listed values
// R16: wait code runs stages, macro untouched
// R17: assist code unsupported, start refused
// R18: software enables macro before manual commands
// R19: drive command, run enabled stages in order
// R20: busy until last stage; start ignored while busy
//
// Decided for this implementation: the register offsets and the APB register port.
module omcs_sequencer
  import omcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_select,
  output logic [3:0] mem_command,
  output logic [3:0] mem_phase,
  output logic busy,
  output logic microsecond_tick
);

  // ===================================================================
  // registers and state
  // ===================================================================
  logic [15:0] rec_timing_ff;
  logic [7:0] key_ff;
  logic [7:0] microsecond_divider_ff;
  logic [31:0] cmd_timing_ff;
  logic [7:0] cmd_select_ff;
  logic refused_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic mem_select_ff;
  logic [3:0] mem_command_ff;
  logic [3:0] mem_phase_ff;
  logic busy_ff;
  logic tick_ff;
  logic [7:0] div_cnt_ff;
  logic [3:0] run_code_ff;
  logic [3:0] run_mask_ff;
  omcs_state_t state_ff;
  omcs_state_t nxt_state;
  logic [17:0] nxt_load_val;
  logic timer_zero;

  // ===================================================================
  // helper functions
  // ===================================================================
  // first enabled stage at or after idx; 4 means none left
  function automatic logic [2:0] first_stage(input logic [3:0] mask,
                                             input logic [2:0] idx);
    logic [2:0] res;
    res = 3'd4;
    for (int i = 3; i >= 0; i--) begin
      if (mask[3-i] && 3'(i) >= idx) begin
        res = 3'(i);
      end
    end
    return res;
  endfunction : first_stage

  function automatic omcs_state_t stage_state(input logic [2:0] idx);
    omcs_state_t s;
    case (idx)
      3'd0: s = ST_SETUP;
      3'd1: s = ST_PULSE;
      3'd2: s = ST_HOLD;
      3'd3: s = ST_RECOV;
      default: s = ST_IDLE;
    endcase
    return s;
  endfunction : stage_state

  // codes that reach the macro; wait and undefined codes do not
  function automatic logic drives_macro(input logic [3:0] code);
    logic r;
    case (code)
      CMD_NOP, CMD_RESET, CMD_POWER_UP, CMD_POWER_DOWN, CMD_READ,
      CMD_WRITE, CMD_PROGRAM, CMD_COMPARE, CMD_PRECHARGE,
      CMD_AUX_UPDATE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : drives_macro

  // ===================================================================
  // apb decode
  // ===================================================================
  wire apb_access = psel && penable && !pready_ff;
  wire apb_done = psel && penable && pready_ff;
  wire wr_done = apb_done && pwrite;
  wire hit_rec = (paddr == OFS_RECOVERY_TIMING);
  wire hit_key = (paddr == OFS_ACCESS_KEY);
  wire hit_div = (paddr == OFS_TICK_DIVIDER);
  wire hit_tim = (paddr == OFS_CMD_TIMING);
  wire hit_sel = (paddr == OFS_CMD_SELECT);
  wire hit_sts = (paddr == OFS_START_STATUS);
  wire hit_any = hit_rec | hit_key | hit_div | hit_tim | hit_sel | hit_sts;

  // read mux; narrow registers sit in the low bits
  wire [31:0] rd_mux =
    hit_rec ? {16'h0000, rec_timing_ff} :
    hit_key ? {24'h000000, key_ff} :
    hit_div ? {24'h000000, microsecond_divider_ff} :
    hit_tim ? cmd_timing_ff :
    hit_sel ? {24'h000000, cmd_select_ff} :
    hit_sts ? {30'h00000000, refused_ff, busy_ff} : 32'h0000_0000;

  // ===================================================================
  // field extraction and start decision
  // ===================================================================
  wire [6:0] f_rst_rec = rec_timing_ff[RST_REC_MSB:RST_REC_LSB]; // [R1]
  wire [8:0] f_psr = rec_timing_ff[PSR_MSB:PSR_LSB]; // [R2]
  wire [17:0] f_pulse = cmd_timing_ff[PULSE_MSB:PULSE_LSB];
  wire [9:0] f_recov = cmd_timing_ff[RECOV_MSB:RECOV_LSB];
  wire [1:0] f_hold = cmd_timing_ff[HOLD_MSB:HOLD_LSB];
  wire [1:0] f_setup = cmd_timing_ff[SETUP_MSB:SETUP_LSB];
  wire [3:0] sel_mask = cmd_select_ff[MASK_MSB:MASK_LSB];
  wire [3:0] sel_code = cmd_select_ff[CODE_MSB:CODE_LSB];
  wire key_ok = (key_ff == KEY_OPEN); // [R3]
  wire start_req = wr_done && hit_sts && pwdata[START_BIT];
  // a start while busy, locked or unsupported is dropped, not queued
  wire start_go = start_req && !busy_ff && key_ok &&
                  (sel_code != CMD_PGM_ASSIST); // [R3] [R17] [R20]
  wire start_bad = start_req && !start_go;
  wire refused_clr = wr_done && hit_sts && pwdata[REFUSED_BIT];

  // ===================================================================
  // stage sequencing
  // ===================================================================
  logic [2:0] cur_idx;
  logic [2:0] next_idx;
  omcs_state_t after_stages;

  // index of the running stage, then the next enabled one
  assign cur_idx = (state_ff == ST_SETUP) ? 3'd0 :
                   (state_ff == ST_PULSE) ? 3'd1 :
                   (state_ff == ST_HOLD) ? 3'd2 : 3'd3;
  assign next_idx = start_go ? first_stage(sel_mask, 3'd0) :
                    first_stage(run_mask_ff, cur_idx + 3'd1); // [R13]
  // supply and reset recovery tail after the last stage
  assign after_stages = (run_code_ff == CMD_POWER_UP) ? ST_PSR :
                        (run_code_ff == CMD_RESET) ? ST_RST : ST_IDLE;

  // next state: stages in fixed order, each gated by its mask bit
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_go) begin
          if (next_idx == 3'd4) begin
            nxt_state = (sel_code == CMD_POWER_UP) ? ST_PSR :
                        (sel_code == CMD_RESET) ? ST_RST : ST_IDLE;
          end else begin
            nxt_state = stage_state(next_idx); // [R19]
          end
        end
      end
      ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOV: begin
        if (timer_zero) begin
          nxt_state = (next_idx == 3'd4) ? after_stages :
                      stage_state(next_idx); // [R19]
        end
      end
      ST_PSR, ST_RST: begin
        if (timer_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // length loaded on entry to each stage and the reset tail, minus one; the supply tail loads its tick count as is
  always_comb begin
    case (nxt_state)
      ST_SETUP: nxt_load_val = {16'h0000, f_setup}; // [R8] [R9]
      ST_PULSE: nxt_load_val = f_pulse; // [R5] [R9]
      ST_HOLD: nxt_load_val = {16'h0000, f_hold}; // [R7]
      ST_RECOV: nxt_load_val = {8'h00, f_recov}; // [R6] [R9]
      ST_PSR: nxt_load_val = {9'h000, f_psr}; // [R2]
      ST_RST: nxt_load_val = {9'h000, f_rst_rec, 2'b11}; // [R1]
      default: nxt_load_val = 18'h00000;
    endcase
  end

  wire entering = (nxt_state != state_ff) && (nxt_state != ST_IDLE);
  // supply wait steps on ticks, everything else on cycles
  wire timer_step = (state_ff == ST_PSR) ? tick_ff : 1'b1;

  omcs_timer #(
    .WIDTH(18)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(entering),
    .load_val(nxt_load_val),
    .step(timer_step),
    .zero(timer_zero)
  );

  // ===================================================================
  // microsecond tick
  // ===================================================================
  // divider write restarts the count so the first tick is clean
  wire div_wr = wr_done && hit_div;
  wire div_wrap = (div_cnt_ff == microsecond_divider_ff); // [R4]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      div_cnt_ff <= (div_wr || div_wrap) ? 8'h00 : div_cnt_ff + 8'h01;
      tick_ff <= div_wrap && !div_wr; // [R4]
    end
  end

  // ===================================================================
  // register file
  // ===================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_timing_ff <= RST_RECOVERY_TIMING;
      key_ff <= RST_ACCESS_KEY;
      microsecond_divider_ff <= RST_TICK_DIVIDER;
      cmd_timing_ff <= RST_CMD_TIMING;
      cmd_select_ff <= RST_CMD_SELECT;
    end else if (wr_done) begin
      if (hit_rec) rec_timing_ff <= pwdata[15:0];
      if (hit_key) key_ff <= pwdata[7:0];
      if (hit_div) microsecond_divider_ff <= pwdata[7:0];
      if (hit_tim) cmd_timing_ff <= pwdata;
      if (hit_sel) cmd_select_ff <= pwdata[7:0];
    end
  end

  // refused start flag: a new refusal beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= start_bad || (refused_ff && !refused_clr);
    end
  end

  // one wait state on every access; data ready with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_access;
      pslverr_ff <= apb_access && !hit_any;
      prdata_ff <= (apb_access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ===================================================================
  // sequencer and macro outputs
  // ===================================================================
  wire nxt_in_stage = (nxt_state == ST_SETUP) || (nxt_state == ST_PULSE) ||
                      (nxt_state == ST_HOLD) || (nxt_state == ST_RECOV);
  wire [3:0] nxt_code = start_go ? sel_code : run_code_ff;
  wire [3:0] nxt_phase = {nxt_state == ST_SETUP, nxt_state == ST_PULSE,
                          nxt_state == ST_HOLD, nxt_state == ST_RECOV};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      run_code_ff <= CMD_NOP;
      run_mask_ff <= 4'h0;
      busy_ff <= 1'b0;
      mem_select_ff <= 1'b0;
      mem_command_ff <= CMD_NOP;
      mem_phase_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (start_go) begin
        run_code_ff <= sel_code; // [R15]
        run_mask_ff <= sel_mask; // [R13]
      end
      busy_ff <= (nxt_state != ST_IDLE); // [R20]
      // wait and undefined codes leave the macro alone
      mem_select_ff <= nxt_in_stage && drives_macro(nxt_code); // [R16]
      mem_command_ff <= (nxt_in_stage && drives_macro(nxt_code)) ?
                        nxt_code : CMD_NOP; // [R15] [R19]
      mem_phase_ff <= drives_macro(nxt_code) ? nxt_phase : 4'h0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mem_select = mem_select_ff;
  assign mem_command = mem_command_ff;
  assign mem_phase = mem_phase_ff;
  assign busy = busy_ff;
  assign microsecond_tick = tick_ff;

  // ===================================================================
  // checks
  // ===================================================================
  // cycles spent in the current state, and since the last tick
  logic [17:0] dwell_ff;
  logic [7:0] tick_gap_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_ff <= 18'h00000;
      tick_gap_ff <= 8'hFF;
    end else begin
      dwell_ff <= (nxt_state != state_ff) ? 18'h00000 : dwell_ff + 18'h1;
      // restart one below zero so the first tick after a restart lines up
      tick_gap_ff <= div_wr ? 8'hFF : tick_ff ? 8'h00 : tick_gap_ff + 8'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a locked start must leave the sequencer idle and flag the refusal
  property p_key_gate;
    start_req && !busy_ff && !key_ok |=> !busy_ff && refused_ff;
  endproperty
  a_key_gate: assert property (p_key_gate) // [R3]
    else $error("start accepted without access key");

  property p_busy_ignore;
    start_req && busy_ff |=> state_ff == $past(state_ff) ||
                             state_ff == ST_IDLE || $past(timer_zero);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) // [R20]
    else $error("start while busy disturbed the sequence");

  property p_assist_refused;
    start_req && !busy_ff && sel_code == CMD_PGM_ASSIST |=> !busy_ff;
  endproperty
  a_assist_refused: assert property (p_assist_refused) // [R17]
    else $error("unsupported assist code was started");

  property p_wait_untouched;
    busy_ff && run_code_ff == CMD_WAIT |-> !mem_select_ff;
  endproperty
  a_wait_untouched: assert property (p_wait_untouched) // [R16]
    else $error("wait command touched the macro");

  property p_pulse_len;
    state_ff == ST_PULSE && dwell_ff == f_pulse |=> state_ff != ST_PULSE;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // [R5]
    else $error("pulse stage length wrong");

  property p_recov_len;
    state_ff == ST_RECOV && dwell_ff < {8'h00, f_recov} |=>
      state_ff == ST_RECOV;
  endproperty
  a_recov_len: assert property (p_recov_len) // [R6]
    else $error("recovery stage ended early");

  property p_hold_len;
    state_ff == ST_HOLD && dwell_ff == {16'h0000, f_hold} |=>
      state_ff != ST_HOLD;
  endproperty
  a_hold_len: assert property (p_hold_len) // [R7]
    else $error("hold stage length wrong");

  sequence s_setup_last;
    state_ff == ST_SETUP && dwell_ff == {16'h0000, f_setup};
  endsequence
  property p_setup_len;
    s_setup_last |=> state_ff != ST_SETUP;
  endproperty
  a_setup_len: assert property (p_setup_len) // [R8]
    else $error("setup stage length wrong");

  property p_order;
    state_ff == ST_PULSE ##1 state_ff != ST_PULSE |-> state_ff != ST_SETUP;
  endproperty
  a_order: assert property (p_order) // [R19]
    else $error("stage order violated");

  property p_tick_period;
    tick_ff |-> tick_gap_ff == microsecond_divider_ff;
  endproperty
  a_tick_period: assert property (p_tick_period) // [R4]
    else $error("microsecond tick period wrong");

  property p_rst_wait;
    state_ff == ST_RST && dwell_ff == {9'h000, f_rst_rec, 2'b11} |=>
      state_ff == ST_IDLE;
  endproperty
  a_rst_wait: assert property (p_rst_wait) // [R1]
    else $error("reset recovery length wrong");

  property p_psr_wait;
    state_ff == ST_PSR && !timer_zero |=> state_ff == ST_PSR;
  endproperty
  a_psr_wait: assert property (p_psr_wait) // [R2]
    else $error("supply recovery ended early");

endmodule : omcs_sequencer

// *** omcs_macro_model.sv ***
// =====================================================================
// omcs_macro_model: records what the sequencer drives at the macro
// =====================================================================
// assumes the pclk domain; the macro has no answer path back.
// the macro counts as enabled by software before any command
module omcs_macro_model (
  input wire logic pclk,
  input wire logic busy,
  input wire logic mem_select,
  input wire logic [3:0] mem_command,
  input wire logic [3:0] mem_phase,
  output int n_su,
  output int n_pu,
  output int n_ho,
  output int n_re,
  output int n_sel,
  output logic [3:0] last_cmd,
  output logic order_bad
);
  logic busy_q = 1'b0;
  logic [2:0] idx;
  logic [2:0] last_idx = 3'h0;

  // stage number of the one-hot phase, 0 between stages
  assign idx = mem_phase[3] ? 3'h1 : mem_phase[2] ? 3'h2 :
    mem_phase[1] ? 3'h3 : mem_phase[0] ? 3'h4 : 3'h0;

  // counts restart when busy rises, so each command stands alone
  always @(posedge pclk) begin
    busy_q <= busy;
    if (busy && !busy_q) begin
      n_su <= mem_phase[3];
      n_pu <= mem_phase[2];
      n_ho <= mem_phase[1];
      n_re <= mem_phase[0];
      n_sel <= mem_select;
      last_idx <= idx;
      order_bad <= 1'b0;
    end else begin
      n_su <= n_su + mem_phase[3];
      n_pu <= n_pu + mem_phase[2];
      n_ho <= n_ho + mem_phase[1];
      n_re <= n_re + mem_phase[0];
      n_sel <= n_sel + mem_select;
      if (idx != 3'h0) last_idx <= idx;
      if (idx != 3'h0 && idx < last_idx) order_bad <= 1'b1;
    end
    if (mem_select) last_cmd <= mem_command;
  end
endmodule : omcs_macro_model

// *** omcs_sequencer_bench.sv ***
// =====================================================================
// omcs_sequencer_bench: apb tests of the manual command sequencer
// =====================================================================
// assumes the offsets of omcs_pkg and the macro model beside the dut.
module omcs_sequencer_bench
  import omcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_select, busy, microsecond_tick, er;
  logic [3:0] mem_command, mem_phase, last_cmd;
  logic order_bad;
  logic [7:0] c;
  int miscompares = 0, tests_run = 0, busy_cnt = 0, b0, g, lo, hi;
  int n_su, n_pu, n_ho, n_re, n_sel;
  // reset words in offset order
  logic [31:0] rv[5] = '{32'h3B2C, 32'h0, 32'h77, 32'h18070, 32'h0};
  // recommended {mask, code} pairs
  logic [7:0] tb[11] = '{8'h00, 8'h44, 8'h45, 8'h51, 8'h58, 8'h59,
    8'hD6, 8'hD7, 8'hDA, 8'hDB, 8'h4D};

  // =====================================================================
  // clock, busy counter, instances
  // =====================================================================
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  omcs_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_select,
    .mem_command, .mem_phase, .busy, .microsecond_tick);
  omcs_macro_model u_macro (.pclk, .busy, .mem_select, .mem_command,
    .mem_phase, .n_su, .n_pu, .n_ho, .n_re, .n_sel, .last_cmd,
    .order_bad);

  // =====================================================================
  // tasks
  // =====================================================================
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, v);
    tests_run++;
    if (v !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, v);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the access phase until pready is sampled high
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) chk("apb_ready", 1, 0);
  endtask : apb

  task automatic wait_idle();
    int k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (busy === 1'b1 && k < 2000);
  endtask : wait_idle

  // start a command and measure how long busy stands
  task automatic run(input logic [7:0] sel, input int lo, hi);
    apb(1, OFS_CMD_SELECT, {24'h0, sel});
    b0 = busy_cnt;
    apb(1, OFS_START_STATUS, 32'h1);
    wait_idle();
    tests_run++;
    if (busy_cnt - b0 < lo || busy_cnt - b0 > hi) begin
      miscompares++;
      $display("MISMATCH busy_cycles exp %0d got %0d", lo, busy_cnt - b0);
    end
  endtask : run

  task automatic tick_gap();
    int k = 0;
    while (microsecond_tick !== 1'b1 && k < 400) begin
      @(negedge pclk);
      k++;
    end
    g = 0;
    do begin
      @(negedge pclk);
      g++;
    end while (microsecond_tick !== 1'b1 && g < 400);
  endtask : tick_gap

  // cycles per enabled stage: setup 2, pulse 4, hold 3, recovery 5
  function automatic int stg(input logic [3:0] m);
    return 2 * m[3] + 4 * m[2] + 3 * m[1] + 5 * m[0];
  endfunction : stg

  // =====================================================================
  // tests
  // =====================================================================
  initial begin
    #100us;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("reset_value", rv[i], rd);
    end
    tick_gap();
    chk("tick_period", 120, g);
    apb(0, 8'h20, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    apb(1, OFS_CMD_TIMING, 32'hFFFF_FFFF);
    apb(0, OFS_CMD_TIMING, 0);
    chk("timing_rw", 32'hFFFF_FFFF, rd);
    apb(1, OFS_RECOVERY_TIMING, 32'hFFFF_FFFF);
    apb(0, OFS_RECOVERY_TIMING, 0);
    chk("recovery_rw", 32'hFFFF, rd);
    // start with the key still locked
    run(8'h46, 0, 0);
    apb(0, OFS_START_STATUS, 0);
    chk("refused_locked", 2, rd);
    apb(1, OFS_START_STATUS, 2);
    apb(1, OFS_ACCESS_KEY, 32'h97);
    apb(1, OFS_TICK_DIVIDER, 32'h9);
    tick_gap();
    chk("tick_period", 10, g);
    // supply tail 2 ticks of 10, reset tail 4*(1+1) cycles
    apb(1, OFS_RECOVERY_TIMING, 32'h202);
    apb(1, OFS_CMD_TIMING, 32'hC049);
    for (int i = 0; i < 11; i++) begin
      c = tb[i];
      lo = stg(c[7:4]);
      hi = lo;
      if (c[3:0] == 4'h4) lo += 10;
      if (c[3:0] == 4'h4) hi += 21;
      if (c[3:0] == 4'h1) lo += 8;
      if (c[3:0] == 4'h1) hi += 9;
      run(c, lo, hi);
      if (c[7:4] != 4'h0) begin
        chk("macro_cycles", c[3:0] == 4'hD ? 0 : stg(c[7:4]), n_sel);
        if (c[3:0] != 4'hD) chk("macro_cmd", c[3:0], last_cmd);
      end
    end
    run(8'hF7, 14, 14);
    chk("setup_len", 2, n_su);
    chk("pulse_len", 4, n_pu);
    chk("hold_len", 3, n_ho);
    chk("recov_len", 5, n_re);
    chk("stage_order", 0, order_bad);
    // undefined code runs its stages like a wait, macro left alone
    run(8'h4C, 4, 4);
    chk("undef_untouched", 0, n_sel);
    // second start while the first still runs
    apb(1, OFS_CMD_SELECT, 32'hD6);
    apb(1, OFS_START_STATUS, 1);
    apb(1, OFS_START_STATUS, 1);
    apb(0, OFS_START_STATUS, 0);
    chk("refused_busy", 3, rd & 32'h3);
    wait_idle();
    apb(1, OFS_START_STATUS, 2);
    // assist timing as software must set it: pulse 6, recovery 7, setup 0
    apb(1, OFS_CMD_TIMING, 32'h18070);
    run(8'hDE, 0, 0);
    apb(0, OFS_START_STATUS, 0);
    chk("refused_assist", 2, rd);
    test_done();
  end
endmodule : omcs_sequencer_bench
